// file: src/smas_device.sv
// Contract
// - 24-bit frame: select, address, direction, data
// - Select 000b reaches register page zero
// - Select 010b reaches register page two
// - Select 111b reaches register page seven
// - Select 001b: data RAM, page bits 11:8
// - Select 011b: development RAM, page bits 13:8
// - Select 100b: program memory, page bits 13:8
// - Direction bit one writes, zero reads
// - Reads force address LSB to zero
// - Read data returns in following frame
// - Master keeps reads inside one word
// - Response header 0000b 0101b, two bytes
// - Master drives input data from rising edge
// - Device changes output at rising edge
// - Every frame shifts MSB first
// - Chip select low frames; high ignores lines
// - Master idles chip select at least 4 us
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module smas_device
	import smas_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	smas_if.device           link,
	output logic             acc_req,
	output smas_sel_t        acc_space,
	output logic [2:0]       register_page_number,
	output logic [13:0]      acc_addr,
	output logic             acc_write,
	output logic [7:0]       acc_wdata,
	input  wire logic        acc_ack,
	input  wire logic [15:0] acc_rdata,
	output logic [5:0]       program_mem_page_reg,
	output logic [5:0]       devel_ram_page_reg,
	output logic [3:0]       data_wave_page_reg
);

	localparam logic [4:0] FRAME_CNT = 5'(FRAME_BITS);
	localparam logic [4:0] OVER_CNT  = 5'(FRAME_BITS + 1);

	logic [1:0]  sclk_sync;
	logic [1:0]  mosi_sync;
	logic [1:0]  csl_sync;
	logic        sclk_q;
	logic        csl_q;
	logic [4:0]  bit_cnt;
	logic [23:0] rx_sr;
	logic [23:0] tx_sr;
	logic        miso_r;
	logic        rd_pending;
	logic [15:0] rd_data;

	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_fall;
	logic        cs_rise;
	logic        active;
	logic        commit;
	smas_sel_t   frame_sel;
	logic [7:0]  frame_addr;
	logic        frame_write;
	logic [7:0]  frame_data;
	logic [7:0]  eff_addr;
	logic        sel_ok;

	// Reserved codes carry no access at all
	function automatic logic sel_valid(input smas_sel_t sel);
		return !(sel == SMAS_SEL_RSV5 || sel == SMAS_SEL_RSV6);
	endfunction

	function automatic logic [2:0] reg_page(input smas_sel_t sel);
		case (sel)
			SMAS_SEL_REG0: reg_page = REG_PAGE0;
			SMAS_SEL_REG2: reg_page = REG_PAGE2;
			SMAS_SEL_REG7: reg_page = REG_PAGE7;
			default:       reg_page = REG_PAGE0;
		endcase
	endfunction

	// Two flops on every pin before any logic looks at it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sclk_sync <= 2'b00;
			mosi_sync <= 2'b00;
			csl_sync  <= 2'b11;
			sclk_q    <= 1'b0;
			csl_q     <= 1'b1;
		end else begin
			sclk_sync <= {sclk_sync[0], link.sclk};
			mosi_sync <= {mosi_sync[0], link.mosi};
			csl_sync  <= {csl_sync[0], link.chip_select_low};
			sclk_q    <= sclk_sync[1];
			csl_q     <= csl_sync[1];
		end
	end

	assign active    = ~csl_sync[1];
	assign sclk_rise = active & sclk_sync[1] & ~sclk_q;
	assign sclk_fall = active & ~sclk_sync[1] & sclk_q;
	assign cs_fall   = ~csl_sync[1] & csl_q;
	assign cs_rise   = csl_sync[1] & ~csl_q;

	// Count bits; a frame longer than 24 also fails the check
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bit_cnt <= 5'h00;
		end else if (cs_fall) begin
			bit_cnt <= 5'h00;
		end else if (sclk_fall && bit_cnt != OVER_CNT) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// input shifts in MSB first, sampled on falling edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_sr <= 24'h000000;
		end else if (sclk_fall) begin
			rx_sr <= {rx_sr[22:0], mosi_sync[1]};
		end
	end

	// field split of a received frame
	assign frame_sel   = smas_sel_t'(rx_sr[SEL_MSB:SEL_LSB]);
	assign frame_addr  = rx_sr[ADDR_MSB:ADDR_LSB];
	assign frame_write = rx_sr[DIR_BIT];
	assign frame_data  = rx_sr[DATA_MSB:DATA_LSB];
	assign sel_ok      = sel_valid(frame_sel);

	// reads land on an even address
	assign eff_addr = frame_write ? frame_addr : {frame_addr[7:1], 1'b0};

	// only a full 24-bit frame takes effect
	assign commit = cs_rise && bit_cnt == FRAME_CNT;

	// direction and data go out with the request
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_req   <= 1'b0;
			acc_write <= 1'b0;
			acc_wdata <= 8'h00;
			acc_space <= SMAS_SEL_REG0;
		end else begin
			acc_req <= commit & sel_ok;
			if (commit && sel_ok) begin
				acc_write <= frame_write;
				acc_wdata <= frame_data;
				acc_space <= frame_sel;
			end
		end
	end

	// Address formed from page register and frame field
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_addr             <= 14'h0000;
			register_page_number <= REG_PAGE0;
		end else if (commit && sel_ok) begin
			register_page_number <= reg_page(frame_sel);
			case (frame_sel)
				SMAS_SEL_DATA:
					acc_addr <= {2'b00, data_wave_page_reg, eff_addr};
				SMAS_SEL_DEVEL:
					acc_addr <= {devel_ram_page_reg, eff_addr};
				SMAS_SEL_PROG:
					acc_addr <= {program_mem_page_reg, eff_addr};
				default:
					acc_addr <= {6'h00, eff_addr};
			endcase
		end
	end

	// Page registers live here since they steer the address
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			program_mem_page_reg <= PROG_PAGE_RST;
			devel_ram_page_reg   <= DEVEL_PAGE_RST;
			data_wave_page_reg   <= DATA_PAGE_RST;
		end else if (commit && frame_write &&
				frame_sel == SMAS_SEL_REG2) begin
			// page two holds the page registers
			case (frame_addr)
				PROG_PAGE_ADDR:  program_mem_page_reg <= frame_data[5:0];
				DEVEL_PAGE_ADDR: devel_ram_page_reg   <= frame_data[5:0];
				DATA_PAGE_ADDR:  data_wave_page_reg   <= frame_data[3:0];
				default:         program_mem_page_reg <= program_mem_page_reg;
			endcase
		end
	end

	// read word kept for the next frame
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_pending <= 1'b0;
			rd_data    <= 16'h0000;
		end else if (commit && !frame_write) begin
			rd_pending <= sel_ok;
			if (!sel_ok) begin
				rd_data <= 16'h0000;
			end
		end else if (rd_pending && acc_ack) begin
			rd_pending <= 1'b0;
			rd_data    <= acc_rdata;
		end
	end

	// response header and data loaded at frame start
	// output changes on the rising edge, and clears to zero at frame start
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_sr  <= 24'h000000;
			miso_r <= 1'b0;
		end else if (cs_fall) begin
			tx_sr  <= {RESP_HDR_HI, RESP_HDR_LO, rd_data};
			miso_r <= 1'b0;
		end else if (sclk_rise) begin
			miso_r <= tx_sr[23];
			tx_sr  <= {tx_sr[22:0], 1'b0};
		end
	end

	// Output released whenever the frame is not ours
	assign link.miso    = miso_r;
	assign link.miso_oe = active;

endmodule

// file: src/smas_pkg.sv
package smas_pkg;

	// Frame layout, most significant bit first on the wire
	localparam int FRAME_BITS = 24;
	localparam int SEL_MSB    = 23;
	localparam int SEL_LSB    = 21;
	localparam int ADDR_MSB   = 20;
	localparam int ADDR_LSB   = 13;
	localparam int DIR_BIT    = 12;
	localparam int DATA_MSB   = 11;
	localparam int DATA_LSB   = 4;

	// Memory-select codes carried in the top three bits
	typedef enum logic [2:0] {
		SMAS_SEL_REG0  = 3'h0,
		SMAS_SEL_DATA  = 3'h1,
		SMAS_SEL_REG2  = 3'h2,
		SMAS_SEL_DEVEL = 3'h3,
		SMAS_SEL_PROG  = 3'h4,
		SMAS_SEL_RSV5  = 3'h5,
		SMAS_SEL_RSV6  = 3'h6,
		SMAS_SEL_REG7  = 3'h7
	} smas_sel_t;

	// Register page numbers for the register spaces
	localparam logic [2:0] REG_PAGE0 = 3'h0;
	localparam logic [2:0] REG_PAGE2 = 3'h2;
	localparam logic [2:0] REG_PAGE7 = 3'h7;

	// Response header nibbles
	localparam logic [3:0] RESP_HDR_HI = 4'h0;
	localparam logic [3:0] RESP_HDR_LO = 4'h5;

	// Page registers, offsets in register page two
	localparam logic [7:0] PROG_PAGE_ADDR  = 8'h18;
	localparam logic [7:0] DATA_PAGE_ADDR  = 8'h19;
	localparam logic [7:0] DEVEL_PAGE_ADDR = 8'h1A;
	localparam logic [5:0] PROG_PAGE_RST   = 6'h00;
	localparam logic [5:0] DEVEL_PAGE_RST  = 6'h00;
	localparam logic [3:0] DATA_PAGE_RST   = 4'h0;

	// Timing
	localparam int SYS_CLK_NS    = 4;
	localparam int CS_IDLE_US    = 4;
	localparam int CS_IDLE_CYC   =
		(CS_IDLE_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int SCLK_HALF_CYC = 8;

	// Controller registers on APB
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RX     = 8'h08;
	localparam int STATUS_BUSY_BIT    = 0;

	typedef enum logic [2:0] {
		SMAS_ST_IDLE  = 3'b001,
		SMAS_ST_SHIFT = 3'b010,
		SMAS_ST_GAP   = 3'b100
	} smas_mst_state_t;

endpackage

// file: src/smas_if.sv
`timescale 1ns/10ps
interface smas_if;
	logic sclk;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic chip_select_low;

	modport device (
		input  sclk,
		input  mosi,
		input  chip_select_low,
		output miso,
		output miso_oe
	);

	modport master (
		output sclk,
		output mosi,
		output chip_select_low,
		input  miso,
		input  miso_oe
	);
endinterface

// file: src/smas_master.sv
`timescale 1ns/10ps
module smas_master
	import smas_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	smas_if.master           link
);

	localparam logic [3:0]  HALF_LAST = 4'(SCLK_HALF_CYC - 1);
	localparam logic [9:0]  GAP_LAST  = 10'(CS_IDLE_CYC - 1);
	localparam logic [4:0]  FRAME_CNT = 5'(FRAME_BITS);

	smas_mst_state_t state;
	logic [1:0]  miso_sync;
	logic [3:0]  half_cnt;
	logic [9:0]  gap_cnt;
	logic [4:0]  bit_cnt;
	logic [23:0] tx_sr;
	logic [23:0] rx_sr;
	logic [23:0] rx_frame;
	logic        sclk_r;
	logic        mosi_r;
	logic        csl_r;
	logic        apb_wr;
	logic        start;
	logic        tick;

	function automatic logic reg_mapped(input logic [7:0] a);
		return a == REG_CMD || a == REG_STATUS || a == REG_RX;
	endfunction

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~reg_mapped(paddr);
	assign apb_wr  = psel & penable & pwrite & reg_mapped(paddr);
	// Command writes while busy are dropped
	assign start   = apb_wr && paddr == REG_CMD &&
		state == SMAS_ST_IDLE;
	assign tick    = half_cnt == HALF_LAST;

	// Read data registered in the setup cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				REG_STATUS: prdata <= {31'h00000000,
					state != SMAS_ST_IDLE};
				REG_RX:     prdata <= {8'h00, rx_frame};
				default:    prdata <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			miso_sync <= 2'b00;
		end else begin
			miso_sync <= {miso_sync[0], link.miso};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			half_cnt <= 4'h0;
		end else if (state != SMAS_ST_SHIFT || tick) begin
			half_cnt <= 4'h0;
		end else begin
			half_cnt <= half_cnt + 4'h1;
		end
	end

	// Serial clock made by dividing the system clock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state    <= SMAS_ST_IDLE;
			sclk_r   <= 1'b0;
			mosi_r   <= 1'b0;
			csl_r    <= 1'b1;
			bit_cnt  <= 5'h00;
			gap_cnt  <= 10'h000;
			tx_sr    <= 24'h000000;
			rx_sr    <= 24'h000000;
			rx_frame <= 24'h000000;
		end else begin
			case (state)
				SMAS_ST_IDLE: begin
					if (start) begin
						tx_sr   <= pwdata[23:0];
						bit_cnt <= 5'h00;
						csl_r   <= 1'b0;
						state   <= SMAS_ST_SHIFT;
					end
				end
				SMAS_ST_SHIFT: begin
					if (tick) begin
						if (bit_cnt == FRAME_CNT) begin
							csl_r    <= 1'b1;
							rx_frame <= rx_sr;
							gap_cnt  <= 10'h000;
							state    <= SMAS_ST_GAP;
						end else if (!sclk_r) begin
							// bit out at rise, MSB first
							sclk_r <= 1'b1;
							mosi_r <= tx_sr[23];
							tx_sr  <= {tx_sr[22:0], 1'b0};
						end else begin
							sclk_r  <= 1'b0;
							rx_sr   <= {rx_sr[22:0], miso_sync[1]};
							bit_cnt <= bit_cnt + 5'h01;
						end
					end
				end
				SMAS_ST_GAP: begin
					// select held high for idle time
					if (gap_cnt == GAP_LAST) begin
						state <= SMAS_ST_IDLE;
					end else begin
						gap_cnt <= gap_cnt + 10'h001;
					end
				end
				default: state <= SMAS_ST_IDLE;
			endcase
		end
	end

	assign link.sclk            = sclk_r;
	assign link.mosi            = mosi_r;
	assign link.chip_select_low = csl_r;

endmodule

// file: tb/smas_checker.sv
`timescale 1ns/10ps
module smas_checker
	import smas_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic chip_select_low
);
	int          gap;
	int          rises;
	logic [23:0] rx_sh;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Saturated in reset, so the first frame may start at once
	always_ff @(posedge sys_clk) begin
		if (rst || !chip_select_low)
			gap <= rst ? CS_IDLE_CYC : 0;
		else if (gap < CS_IDLE_CYC)
			gap <= gap + 1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst || chip_select_low)
			rises <= 0;
		else if (sclk && !$past(sclk))
			rises <= rises + 1;
	end

	always_ff @(posedge sys_clk) begin
		if (!sclk && $past(sclk))
			rx_sh <= {rx_sh[22:0], miso};
	end

	property p_sclk_idle;
		chip_select_low |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("serial clock moves while deselected");

	property p_gap;
		$fell(chip_select_low) |-> gap >= CS_IDLE_CYC;
	endproperty
	a_gap: assert property (p_gap)
		else $error("select idle time too short");

	property p_mosi_edge;
		!chip_select_low && $changed(mosi) |-> $rose(sclk);
	endproperty
	a_mosi_edge: assert property (p_mosi_edge)
		else $error("master data changed off clock rise");

	property p_miso_edge;
		miso_oe && $past(miso_oe, 4) && $changed(miso) |-> sclk;
	endproperty
	a_miso_edge: assert property (p_miso_edge)
		else $error("device data changed while clock low");

	property p_oe_on;
		$fell(chip_select_low) |-> ##[1:4] miso_oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("device did not drive when selected");

	property p_oe_off;
		$rose(chip_select_low) |-> ##[1:4] !miso_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("device kept driving when deselected");

	property p_bits;
		$rose(chip_select_low) |-> rises == FRAME_BITS;
	endproperty
	a_bits: assert property (p_bits)
		else $error("frame bit count wrong");

	property p_header;
		$rose(chip_select_low) |-> rx_sh[23:16] == 8'h05;
	endproperty
	a_header: assert property (p_header)
		else $error("response header wrong");

	c_frame: cover property ($rose(chip_select_low) && rises == FRAME_BITS);
	c_miso: cover property (miso_oe && miso);
	c_start: cover property ($fell(chip_select_low));
endmodule

// file: tb/spi_memory_access_slave_test.sv
`timescale 1ns/10ps
module spi_memory_access_slave_test import smas_pkg::*;;
	logic        sys_clk = 0;
	logic        rst = 1;
	logic [7:0]  paddr = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic        pready, pslverr, acc_req, acc_write, req2, e, w;
	logic        acc_ack = 0, pr = 0;
	smas_sel_t   acc_space;
	logic [2:0]  register_page_number, s;
	logic [13:0] acc_addr;
	logic [7:0]  acc_wdata, a, dd;
	logic [15:0] acc_rdata = 0;
	logic [5:0]  program_mem_page_reg, devel_ram_page_reg, pp2, pp, pv;
	logic [3:0]  data_wave_page_reg, pd;
	logic [23:0] pend;
	int          err_total = 0, compares = 0, nreq = 0, nreq2 = 0, b;

	smas_if link ();
	smas_if l2 ();
	always #2 sys_clk = ~sys_clk;

	smas_master smas_master_i (.sys_clk, .rst, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .link(link));
	smas_device smas_device_i (.sys_clk, .rst, .link(link), .acc_req,
		.acc_space, .register_page_number, .acc_addr, .acc_write,
		.acc_wdata, .acc_ack, .acc_rdata, .program_mem_page_reg,
		.devel_ram_page_reg, .data_wave_page_reg);
	// Second end fed by the bench to send broken frames
	smas_device smas_device_i2 (.sys_clk, .rst, .link(l2), .acc_req(req2),
		.acc_space(), .register_page_number(), .acc_addr(), .acc_write(),
		.acc_wdata(), .acc_ack(1'h0), .acc_rdata(16'h0),
		.program_mem_page_reg(pp2), .devel_ram_page_reg(),
		.data_wave_page_reg());
	smas_checker smas_checker_i (.sys_clk, .rst, .sclk(link.sclk),
		.mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
		.chip_select_low(link.chip_select_low));

	function logic [15:0] rd(logic [13:0] x);
		return {x[7:0] ^ 8'h5A, x[13:6]};
	endfunction

	function logic [13:0] ea(logic [2:0] c, logic [7:0] v, logic r);
		case (c)
			3'h1: ea = {2'h0, pd, v};
			3'h3: ea = {pv, v};
			3'h4: ea = {pp, v};
			default: ea = {6'h0, v};
		endcase
		ea[0] = ea[0] & r;
	endfunction

	always @(posedge sys_clk) begin
		acc_ack <= acc_req;
		acc_rdata <= rd(acc_addr);
		nreq += acc_req;
		nreq2 += req2;
	end

	task chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, g, x);
		end
	endtask

	task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		paddr <= ad;
		pwrite <= wr;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task frame(input logic [23:0] f);
		apb(1, REG_CMD, {8'h0, f});
		repeat (4) @(posedge sys_clk);
		do apb(0, REG_STATUS, 0); while (q[0] !== 1'h0);
		apb(0, REG_RX, 0);
	endtask

	task raw(input logic [23:0] f, input int n);
		l2.chip_select_low <= 0;
		repeat (8) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			l2.mosi <= f[23 - i];
			l2.sclk <= 1;
			repeat (4) @(posedge sys_clk);
			l2.sclk <= 0;
			repeat (4) @(posedge sys_clk);
		end
		l2.chip_select_low <= 1;
		// Released line shows no stale level
		l2.mosi <= ~l2.mosi;
		repeat (CS_IDLE_CYC) @(posedge sys_clk);
	endtask

	task report_and_stop;
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#300000;
		err_total++;
		report_and_stop;
	end

	initial begin
		l2.sclk = 0;
		l2.mosi = 0;
		l2.chip_select_low = 1;
		b = $urandom(54);
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		apb(0, 8'h0C, 0);
		chk(e, 1);
		pp = 6'($urandom);
		pd = 4'($urandom);
		pv = 6'($urandom);
		frame({3'h2, PROG_PAGE_ADDR, 1'h1, 2'h0, pp, 4'h0});
		frame({3'h2, DATA_PAGE_ADDR, 1'h1, 4'h0, pd, 4'h0});
		frame({3'h2, DEVEL_PAGE_ADDR, 1'h1, 2'h0, pv, 4'h0});
		chk({program_mem_page_reg, data_wave_page_reg,
			devel_ram_page_reg}, {pp, pd, pv});
		chk(e, 0);
		// Writes over every code, then odd-address reads
		for (int i = 0; i < 17; i++) begin
			s = 3'(i);
			w = i < 8;
			a = 8'($urandom) & 8'hF7;
			a[0] = ~w;
			dd = 8'($urandom);
			b = nreq;
			frame({s, a, w, dd, 4'(i)});
			if (pr) chk(q[23:0], pend);
			pr = !w;
			// only the aligned word comes back
			pend = {8'h05, (s == 3'h5 || s == 3'h6) ? 16'h0
				: rd(ea(s, a, w))};
			if (s == 3'h5 || s == 3'h6)
				chk(nreq, b);
			else begin
				chk(nreq, b + 1);
				chk(acc_addr, ea(s, a, w));
				chk({acc_space, register_page_number, acc_write},
					{s, (s == 3'h2 || s == 3'h7) ? s : 3'h0, w});
				if (w) chk(acc_wdata, dd);
			end
		end
		raw({3'h2, PROG_PAGE_ADDR, 1'h1, 8'h2A, 4'h0}, 12);
		chk(nreq2, 0);
		chk(pp2, 0);
		raw({3'h2, PROG_PAGE_ADDR, 1'h1, 8'h2A, 4'h0}, 24);
		chk(nreq2, 1);
		chk(pp2, 6'h2A);
		report_and_stop;
	end
endmodule
